// file: hdl/eqm_pkg.sv
package eqm_pkg;
    // register offsets
    localparam logic [7:0] EQM_ADDR_CTRL = 8'h35;
    localparam logic [7:0] EQM_ADDR_PCLK = 8'h39;
    localparam logic [7:0] EQM_ADDR_DIV = 8'h3a;
    localparam logic [7:0] EQM_ADDR_STAT = 8'h3b;
    localparam logic [7:0] EQM_ADDR_STATIC = 8'h44;
    localparam logic [7:0] EQM_ADDR_FLOOR = 8'h45;
    localparam logic [7:0] EQM_ADDR_MAP = 8'h49;
    // reset values
    localparam logic [7:0] EQM_RST_CTRL = 8'h00;
    localparam logic [7:0] EQM_RST_PCLK = 8'h00;
    localparam logic [7:0] EQM_RST_DIV = 8'h00;
    localparam logic [7:0] EQM_RST_STATIC = 8'h60;
    localparam logic [7:0] EQM_RST_FLOOR = 8'h88;
    localparam logic [7:0] EQM_RST_MAP = 8'h00;
    localparam logic [7:0] EQM_RST_RDATA = 8'h00;
    // writable bit masks
    localparam logic [7:0] EQM_WM_CTRL = 8'h70;
    localparam logic [7:0] EQM_WM_PCLK = 8'h02;
    localparam logic [7:0] EQM_WM_DIV = 8'hf0;
    localparam logic [7:0] EQM_WM_STATIC = 8'hef;
    localparam logic [7:0] EQM_WM_FLOOR = 8'h0f;
    localparam logic [7:0] EQM_WM_MAP = 8'h60;
    // field positions
    localparam int EQM_CTRL_RESTART = 6;
    localparam int EQM_CTRL_LCB_OVR = 5;
    localparam int EQM_CTRL_LCB = 4;
    localparam int EQM_PCLK_INT = 1;
    localparam int EQM_DIV_OVR = 7;
    localparam int EQM_DIV_SEL_LSB = 4;
    localparam int EQM_STAGE1_LSB = 5;
    localparam int EQM_STAGE2_LSB = 1;
    localparam int EQM_BYPASS = 0;
    localparam int EQM_FLOOR_LSB = 0;
    localparam int EQM_MAP_PIN = 7;
    localparam int EQM_MAP_OVR = 6;
    localparam int EQM_MAP_SEL = 5;
    // widths
    localparam int EQM_LEVEL_W = 6;
    localparam int EQM_STAGE_W = 3;
    localparam int EQM_FLOOR_W = 4;
    localparam int EQM_LANE_W = 4;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] pclk;
        logic [7:0] div;
        logic [7:0] static_set;
        logic [7:0] floor_lim;
        logic [7:0] map;
        logic [7:0] rdata;
        logic restart;
        logic long_cable;
        logic [EQM_FLOOR_W-1:0] floor;
        logic bypass;
        logic [EQM_STAGE_W-1:0] stage1;
        logic [EQM_STAGE_W-1:0] stage2;
        logic [EQM_LEVEL_W-1:0] level;
        logic pclk_int;
        logic div_ovr;
        logic [2:0] div_sel;
        logic map_sel;
        logic [EQM_LANE_W-1:0] lane3;
    } eqm_state_t;
endpackage

// file: hdl/eqm_regs.sv
// Operation
// R1 - restart bit set: equalizer adaptation restarts from its floor values
// R2 - restart bit never self-clears; software sets then clears it
// R3 - long-cable override 0 takes mode from strap pin, 1 from register
// R4 - long-cable register bit selected enables mode and floor from floor field
// R5 - pattern clock bit selects internal pixel clock, else external
// R6 - divider override bit 7 applies divider field bits 6:4
// R7 - status bits 5:0 report equalizer level actually applied
// R8 - bypass bit stops adaptive search and applies static stage values
// R9 - stage one value bits 7:5 used only while bypassed
// R10 - stage two value bits 3:1 used only while bypassed
// R11 - floor field sets lowest search level whenever long-cable mode active
// R12 - map register bit 7 reads current bit-map select pin level
// R13 - map override 0 takes selection from pin, 1 from bit 5
// R14 - selection 0 puts low colour bits on lane 3, 1 high bits
// R15 - after reset static setting holds 0x60, floor limit holds 0x88
// R16 - reserved bits read reset values and ignore writes
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module eqm_regs (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic long_cable_mode_strap_i,
    input wire logic bit_map_select_pin_i,
    input wire logic [eqm_pkg::EQM_LEVEL_W-1:0] search_level_i,
    input wire logic [eqm_pkg::EQM_LANE_W-1:0] colour_lsb_i,
    input wire logic [eqm_pkg::EQM_LANE_W-1:0] colour_msb_i,
    output logic adaptive_equalizer_restart_o,
    output logic long_cable_mode_o,
    output logic [eqm_pkg::EQM_FLOOR_W-1:0] eq_floor_o,
    output logic eq_bypass_o,
    output logic [eqm_pkg::EQM_STAGE_W-1:0] eq_stage1_o,
    output logic [eqm_pkg::EQM_STAGE_W-1:0] eq_stage2_o,
    output logic [eqm_pkg::EQM_LEVEL_W-1:0] eq_level_o,
    output logic pattern_internal_clock_en_o,
    output logic mclk_div_override_o,
    output logic [2:0] mclk_div_sel_o,
    output logic bit_map_select_o,
    output logic [eqm_pkg::EQM_LANE_W-1:0] lvds_lane3_out_o
);
    import eqm_pkg::*;

    eqm_state_t state_ff;
    eqm_state_t nxt_state;
    logic [EQM_LEVEL_W-1:0] floor_eff;
    logic [EQM_LEVEL_W-1:0] static_level;
    logic lcb_pick;
    logic map_pick;

    // floor applies only while long-cable mode is active
    always_comb begin
        if (state_ff.long_cable) begin
            floor_eff = {2'b00, state_ff.floor}; // [R11]
        end else begin
            floor_eff = '0;
        end
        static_level = {state_ff.stage1, state_ff.stage2};
        if (state_ff.ctrl[EQM_CTRL_LCB_OVR]) begin
            lcb_pick = state_ff.ctrl[EQM_CTRL_LCB]; // [R3] [R4]
        end else begin
            lcb_pick = long_cable_mode_strap_i; // [R3]
        end
        if (state_ff.map[EQM_MAP_OVR]) begin
            map_pick = state_ff.map[EQM_MAP_SEL]; // [R13]
        end else begin
            map_pick = bit_map_select_pin_i; // [R13]
        end
    end

    always_comb begin
        nxt_state = state_ff;
        // register writes, reserved bits keep their values
        if (wr_i) begin
            if (addr_i == EQM_ADDR_CTRL) begin
                nxt_state.ctrl = (state_ff.ctrl & ~EQM_WM_CTRL) |
                    (wdata_i & EQM_WM_CTRL); // [R16] [R2]
            end else if (addr_i == EQM_ADDR_PCLK) begin
                nxt_state.pclk = (state_ff.pclk & ~EQM_WM_PCLK) |
                    (wdata_i & EQM_WM_PCLK); // [R16]
            end else if (addr_i == EQM_ADDR_DIV) begin
                nxt_state.div = (state_ff.div & ~EQM_WM_DIV) |
                    (wdata_i & EQM_WM_DIV); // [R16]
            end else if (addr_i == EQM_ADDR_STATIC) begin
                nxt_state.static_set =
                    (state_ff.static_set & ~EQM_WM_STATIC) |
                    (wdata_i & EQM_WM_STATIC); // [R16]
            end else if (addr_i == EQM_ADDR_FLOOR) begin
                nxt_state.floor_lim =
                    (state_ff.floor_lim & ~EQM_WM_FLOOR) |
                    (wdata_i & EQM_WM_FLOOR); // [R16]
            end else if (addr_i == EQM_ADDR_MAP) begin
                nxt_state.map = (state_ff.map & ~EQM_WM_MAP) |
                    (wdata_i & EQM_WM_MAP); // [R16] [R12]
            end
        end
        // read data stands for one cycle only
        nxt_state.rdata = 8'h00;
        if (rd_i) begin
            if (addr_i == EQM_ADDR_CTRL) begin
                nxt_state.rdata = state_ff.ctrl;
            end else if (addr_i == EQM_ADDR_PCLK) begin
                nxt_state.rdata = state_ff.pclk;
            end else if (addr_i == EQM_ADDR_DIV) begin
                nxt_state.rdata = state_ff.div;
            end else if (addr_i == EQM_ADDR_STAT) begin
                nxt_state.rdata = {2'b00, state_ff.level}; // [R7]
            end else if (addr_i == EQM_ADDR_STATIC) begin
                nxt_state.rdata = state_ff.static_set;
            end else if (addr_i == EQM_ADDR_FLOOR) begin
                nxt_state.rdata = state_ff.floor_lim; // [R16]
            end else if (addr_i == EQM_ADDR_MAP) begin
                nxt_state.rdata = {bit_map_select_pin_i,
                    state_ff.map[6:0]}; // [R12]
            end
        end
        // control decode from stored registers, strap, map pin and colour inputs
        nxt_state.restart = state_ff.ctrl[EQM_CTRL_RESTART]; // [R1]
        nxt_state.long_cable = lcb_pick; // [R3] [R4]
        nxt_state.floor =
            state_ff.floor_lim[EQM_FLOOR_LSB +: EQM_FLOOR_W]; // [R4]
        nxt_state.bypass = state_ff.static_set[EQM_BYPASS]; // [R8]
        nxt_state.stage1 =
            state_ff.static_set[EQM_STAGE1_LSB +: EQM_STAGE_W]; // [R9]
        nxt_state.stage2 =
            state_ff.static_set[EQM_STAGE2_LSB +: EQM_STAGE_W]; // [R10]
        nxt_state.pclk_int = state_ff.pclk[EQM_PCLK_INT]; // [R5]
        nxt_state.div_ovr = state_ff.div[EQM_DIV_OVR]; // [R6]
        if (state_ff.div[EQM_DIV_OVR]) begin
            nxt_state.div_sel = state_ff.div[EQM_DIV_SEL_LSB +: 3]; // [R6]
        end else begin
            nxt_state.div_sel = 3'h0;
        end
        nxt_state.map_sel = map_pick; // [R13]
        if (state_ff.map_sel) begin
            nxt_state.lane3 = colour_msb_i; // [R14]
        end else begin
            nxt_state.lane3 = colour_lsb_i; // [R14]
        end
        // applied equalizer level
        if (state_ff.bypass) begin
            nxt_state.level = static_level; // [R8] [R9] [R10]
        end else if (state_ff.restart) begin
            nxt_state.level = floor_eff; // [R1]
        end else if (search_level_i < floor_eff) begin
            nxt_state.level = floor_eff; // [R11]
        end else begin
            nxt_state.level = search_level_i; // [R7]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
            state_ff.ctrl <= EQM_RST_CTRL;
            state_ff.pclk <= EQM_RST_PCLK;
            state_ff.div <= EQM_RST_DIV;
            state_ff.static_set <= EQM_RST_STATIC; // [R15]
            state_ff.floor_lim <= EQM_RST_FLOOR; // [R15]
            state_ff.map <= EQM_RST_MAP;
            state_ff.rdata <= EQM_RST_RDATA;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata_o = state_ff.rdata;
    assign adaptive_equalizer_restart_o = state_ff.restart;
    assign long_cable_mode_o = state_ff.long_cable;
    assign eq_floor_o = state_ff.floor;
    assign eq_bypass_o = state_ff.bypass;
    assign eq_stage1_o = state_ff.stage1;
    assign eq_stage2_o = state_ff.stage2;
    assign eq_level_o = state_ff.level;
    assign pattern_internal_clock_en_o = state_ff.pclk_int;
    assign mclk_div_override_o = state_ff.div_ovr;
    assign mclk_div_sel_o = state_ff.div_sel;
    assign bit_map_select_o = state_ff.map_sel;
    assign lvds_lane3_out_o = state_ff.lane3;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_ctrl_write;
        wr_i && (addr_i == EQM_ADDR_CTRL);
    endsequence

    sequence s_restart_held;
        state_ff.ctrl[EQM_CTRL_RESTART] ##1 state_ff.restart;
    endsequence

    sequence s_restart_write;
        wr_i && (addr_i == EQM_ADDR_CTRL) && wdata_i[EQM_CTRL_RESTART];
    endsequence

    sequence s_restart_seen;
        ##2 adaptive_equalizer_restart_o;
    endsequence

    sequence s_bypass_write;
        wr_i && (addr_i == EQM_ADDR_STATIC) && wdata_i[EQM_BYPASS];
    endsequence

    sequence s_bypass_applied;
        ##2 eq_bypass_o ##1 eq_level_o == $past(static_level);
    endsequence

    a_restart_sticky: assert property ( // [R2]
        (state_ff.ctrl[EQM_CTRL_RESTART] && !(wr_i &&
            addr_i == EQM_ADDR_CTRL)) |=> state_ff.ctrl[EQM_CTRL_RESTART])
        else $error("restart bit cleared itself");

    a_restart_floor_level: assert property ( // [R1]
        (s_restart_held and (!state_ff.bypass [*2]))
        |=> eq_level_o == $past(floor_eff))
        else $error("restart did not apply floor level");

    a_long_cable_source: assert property ( // [R3]
        1'b1 |=> long_cable_mode_o == $past(lcb_pick))
        else $error("long-cable source wrong");

    a_long_cable_reg: assert property ( // [R4]
        (state_ff.ctrl[EQM_CTRL_LCB_OVR] && state_ff.ctrl[EQM_CTRL_LCB])
        |=> long_cable_mode_o && eq_floor_o == $past(state_ff.floor_lim[3:0]))
        else $error("register long-cable mode not applied");

    a_floor_lowest: assert property ( // [R11]
        (state_ff.long_cable && !state_ff.bypass)
        |=> eq_level_o >= {2'b00, $past(state_ff.floor)})
        else $error("level below floor in long-cable mode");

    a_pclk_select: assert property ( // [R5]
        1'b1 |=> pattern_internal_clock_en_o ==
            $past(state_ff.pclk[EQM_PCLK_INT]))
        else $error("pattern clock select wrong");

    a_div_override: assert property ( // [R6]
        state_ff.div[EQM_DIV_OVR] |=> mclk_div_override_o &&
            mclk_div_sel_o == $past(state_ff.div[6:4]))
        else $error("divider override not applied");

    a_div_no_override: assert property ( // [R6]
        !state_ff.div[EQM_DIV_OVR] |=> !mclk_div_override_o)
        else $error("divider overridden while disabled");

    a_status_read: assert property ( // [R7]
        (rd_i && addr_i == EQM_ADDR_STAT)
        |=> rdata_o == {2'b00, $past(state_ff.level)})
        else $error("status read mismatch");

    a_bypass_static: assert property ( // [R8] [R9] [R10]
        state_ff.bypass |=> eq_level_o == $past(static_level))
        else $error("bypass level not static stage values");

    a_pin_readback: assert property ( // [R12]
        (rd_i && addr_i == EQM_ADDR_MAP)
        |=> rdata_o[7] == $past(bit_map_select_pin_i))
        else $error("map pin readback wrong");

    a_map_source: assert property ( // [R13]
        1'b1 |=> bit_map_select_o == $past(map_pick))
        else $error("map select source wrong");

    a_lane3_order: assert property ( // [R14]
        state_ff.map_sel |=> lvds_lane3_out_o == $past(colour_msb_i))
        else $error("lane 3 bit order wrong");

    a_reserved_floor: assert property ( // [R16]
        (rd_i && addr_i == EQM_ADDR_FLOOR) |=> rdata_o[7:4] == 4'h8)
        else $error("reserved floor bits changed");

    a_read_one_cycle: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data stood beyond one cycle");

    a_restart_pipe: assert property ( // [R1]
        s_restart_write |-> s_restart_seen)
        else $error("restart write did not reach output");

    a_bypass_pipe: assert property ( // [R8]
        s_bypass_write |-> s_bypass_applied)
        else $error("bypass write did not apply static level");

    a_ctrl_write_lands: assert property ( // [R2] [R16]
        s_ctrl_write |=> state_ff.ctrl == ($past(wdata_i) & EQM_WM_CTRL))
        else $error("control write did not land");

    a_restart_out: assert property ( // [R1]
        reset_n_i |=> adaptive_equalizer_restart_o ==
            $past(state_ff.ctrl[EQM_CTRL_RESTART]))
        else $error("restart output does not follow bit");

    a_reserved_ctrl: assert property ( // [R16]
        (state_ff.ctrl & ~EQM_WM_CTRL) == (EQM_RST_CTRL & ~EQM_WM_CTRL))
        else $error("reserved control bits changed");

    a_reserved_pclk: assert property ( // [R16]
        (state_ff.pclk & ~EQM_WM_PCLK) == (EQM_RST_PCLK & ~EQM_WM_PCLK))
        else $error("reserved pattern clock bits changed");

    a_reserved_div: assert property ( // [R16]
        (state_ff.div & ~EQM_WM_DIV) == (EQM_RST_DIV & ~EQM_WM_DIV))
        else $error("reserved divider bits changed");

    a_reserved_static: assert property ( // [R16]
        (state_ff.static_set & ~EQM_WM_STATIC) ==
            (EQM_RST_STATIC & ~EQM_WM_STATIC))
        else $error("reserved static bits changed");

    a_reserved_map: assert property ( // [R16]
        (state_ff.map & ~EQM_WM_MAP) == (EQM_RST_MAP & ~EQM_WM_MAP))
        else $error("reserved map bits changed");

    a_reserved_floor_reg: assert property ( // [R16]
        (state_ff.floor_lim & ~EQM_WM_FLOOR) ==
            (EQM_RST_FLOOR & ~EQM_WM_FLOOR))
        else $error("reserved floor register bits changed");

    a_floor_out: assert property ( // [R11]
        reset_n_i |=> eq_floor_o ==
            $past(state_ff.floor_lim[EQM_FLOOR_LSB +: EQM_FLOOR_W]))
        else $error("floor output does not follow field");

    a_bypass_out: assert property ( // [R8]
        reset_n_i |=>
            eq_bypass_o == $past(state_ff.static_set[EQM_BYPASS]))
        else $error("bypass output does not follow bit");

    a_stage_out: assert property ( // [R9] [R10]
        reset_n_i |=>
            eq_stage1_o == $past(state_ff.static_set[7:5]) &&
            eq_stage2_o == $past(state_ff.static_set[3:1]))
        else $error("stage outputs do not follow register");

    a_lane3_low: assert property ( // [R14]
        (reset_n_i && !state_ff.map_sel)
        |=> lvds_lane3_out_o == $past(colour_lsb_i))
        else $error("lane 3 low group not applied");

    a_div_sel_zero: assert property ( // [R6]
        !state_ff.div[EQM_DIV_OVR] |=> mclk_div_sel_o == 3'h0)
        else $error("divider select driven without override");

    a_search_pass: assert property ( // [R7]
        (reset_n_i && !state_ff.bypass && !state_ff.restart &&
            !state_ff.long_cable) |=> eq_level_o == $past(search_level_i))
        else $error("search level not applied");

    a_search_above: assert property ( // [R7] [R11]
        (!state_ff.bypass && !state_ff.restart && state_ff.long_cable &&
            search_level_i >= floor_eff)
        |=> eq_level_o == $past(search_level_i))
        else $error("search level above floor not applied");

    a_restart_short: assert property ( // [R1]
        (!state_ff.bypass && state_ff.restart && !state_ff.long_cable)
        |=> eq_level_o == 6'h00)
        else $error("restart level not zero without long cable");

    a_read_ctrl: assert property ( // [R2]
        (rd_i && addr_i == EQM_ADDR_CTRL)
        |=> rdata_o == $past(state_ff.ctrl))
        else $error("control read mismatch");

    a_read_static: assert property ( // [R16]
        (rd_i && addr_i == EQM_ADDR_STATIC)
        |=> rdata_o == $past(state_ff.static_set))
        else $error("static setting read mismatch");

    a_read_map_bits: assert property ( // [R13]
        (rd_i && addr_i == EQM_ADDR_MAP)
        |=> rdata_o[6:0] == $past(state_ff.map[6:0]))
        else $error("map register read mismatch");

    a_read_unmapped: assert property ( // [R16]
        (rd_i && addr_i != EQM_ADDR_CTRL && addr_i != EQM_ADDR_PCLK &&
            addr_i != EQM_ADDR_DIV && addr_i != EQM_ADDR_STAT &&
            addr_i != EQM_ADDR_STATIC && addr_i != EQM_ADDR_FLOOR &&
            addr_i != EQM_ADDR_MAP) |=> rdata_o == 8'h00)
        else $error("unmapped read returned data");

endmodule // eqm_regs

// file: sim/eqm_regs_tb.sv
`timescale 1ns/1ps
module eqm_regs_tb;
    import eqm_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic strap = 1'b0;
    logic map_pin = 1'b0;
    logic [5:0] search = 6'h00;
    logic [3:0] col_lo = 4'h3;
    logic [3:0] col_hi = 4'hc;
    logic restart, lcb, byp, pint, dovr, msel;
    logic [3:0] floor_v, lane3;
    logic [2:0] st1, st2, dsel;
    logic [5:0] level;
    int bad_count = 0;
    int n_compared = 0;

    eqm_regs u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .long_cable_mode_strap_i(strap), .bit_map_select_pin_i(map_pin),
        .search_level_i(search), .colour_lsb_i(col_lo), .colour_msb_i(col_hi),
        .adaptive_equalizer_restart_o(restart), .long_cable_mode_o(lcb),
        .eq_floor_o(floor_v), .eq_bypass_o(byp), .eq_stage1_o(st1),
        .eq_stage2_o(st2), .eq_level_o(level),
        .pattern_internal_clock_en_o(pint), .mclk_div_override_o(dovr),
        .mclk_div_sel_o(dsel), .bit_map_select_o(msel),
        .lvds_lane3_out_o(lane3));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // reset values and derived outputs
    task automatic t_reset();
        rd(EQM_ADDR_CTRL, 8'h00);
        rd(EQM_ADDR_STATIC, 8'h60);
        rd(EQM_ADDR_FLOOR, 8'h88);
        rd(EQM_ADDR_PCLK, 8'h00);
        rd(EQM_ADDR_DIV, 8'h00);
        wt(2);
        chk(8'({st1, st2, byp}), 8'h30);
        chk(8'(floor_v), 8'h08);
    endtask

    // restart level holds until cleared
    task automatic t_restart();
        @(posedge clk_i);
        search <= 6'h05;
        wr(EQM_ADDR_CTRL, 8'h40);
        wt(12);
        chk(8'(restart), 8'h01);
        chk(8'(level), 8'h00);
        wr(EQM_ADDR_CTRL, 8'h00);
        wt(4);
        chk(8'(restart), 8'h00);
        chk(8'(level), 8'h05);
    endtask

    // long-cable source and floor
    task automatic t_lcb();
        @(posedge clk_i);
        strap <= 1'b1;
        search <= 6'h03;
        wr(EQM_ADDR_FLOOR, 8'hfa);
        rd(EQM_ADDR_FLOOR, 8'h8a);
        wt(4);
        chk(8'(lcb), 8'h01);
        chk(8'(level), 8'h0a);
        wr(EQM_ADDR_CTRL, 8'h20);
        wt(4);
        chk(8'(lcb), 8'h00);
        @(posedge clk_i);
        strap <= 1'b0;
        wr(EQM_ADDR_CTRL, 8'h30);
        wt(4);
        chk(8'(lcb), 8'h01);
        chk({floor_v, 2'h0, level[5:4]}, 8'ha0);
        chk(8'(level), 8'h0a);
        @(posedge clk_i);
        search <= 6'h0c;
        wt(3);
        chk(8'(level), 8'h0c);
        @(posedge clk_i);
        search <= 6'h03;
        wr(EQM_ADDR_CTRL, 8'h00);
        wt(4);
        chk(8'(level), 8'h03);
    endtask

    // static stages under bypass
    task automatic t_bypass();
        wr(EQM_ADDR_STATIC, 8'hb7);
        rd(EQM_ADDR_STATIC, 8'ha7);
        wt(4);
        chk(8'({st1, st2, byp}), 8'h57);
        chk(8'(level), 8'h2b);
        rd(EQM_ADDR_STAT, 8'h2b);
        wr(EQM_ADDR_STAT, 8'hff);
        rd(EQM_ADDR_STAT, 8'h2b);
        wr(EQM_ADDR_STATIC, 8'ha6);
        wt(4);
        chk(8'(byp), 8'h00);
        chk(8'(level), 8'h03);
    endtask

    // pattern clock and divider override
    task automatic t_misc();
        wr(EQM_ADDR_PCLK, 8'hff);
        rd(EQM_ADDR_PCLK, 8'h02);
        wt(2);
        chk(8'(pint), 8'h01);
        wr(EQM_ADDR_PCLK, 8'h00);
        wr(EQM_ADDR_DIV, 8'hd5);
        rd(EQM_ADDR_DIV, 8'hd0);
        wt(2);
        chk(8'({pint, dovr, dsel}), 8'h0d);
        wr(EQM_ADDR_DIV, 8'h50);
        wt(3);
        chk(8'({dovr, dsel}), 8'h00);
    endtask

    // bit-map pin readback, override and lane 3
    task automatic t_map();
        @(posedge clk_i);
        map_pin <= 1'b1;
        rd(EQM_ADDR_MAP, 8'h80);
        wt(4);
        chk(8'({msel, lane3}), 8'h1c);
        wr(EQM_ADDR_MAP, 8'h40);
        wt(4);
        chk(8'({msel, lane3}), 8'h03);
        @(posedge clk_i);
        col_lo <= 4'h6;
        wt(3);
        chk(8'({msel, lane3}), 8'h06);
        @(posedge clk_i);
        map_pin <= 1'b0;
        wr(EQM_ADDR_MAP, 8'hff);
        rd(EQM_ADDR_MAP, 8'h60);
        wt(4);
        chk(8'({msel, lane3}), 8'h1c);
        @(posedge clk_i);
        col_hi <= 4'h9;
        wt(3);
        chk(8'({msel, lane3}), 8'h19);
        rd(8'h50, 8'h00);
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_restart();
        t_lcb();
        t_bypass();
        t_misc();
        t_map();
        give_verdict();
    end
endmodule // eqm_regs_tb
